// file: bench/can_bus_node.sv
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       go,
  input  wire logic       stall,
  input  wire logic       fail,
  input  wire logic [7:0] TX_BYTE,
  input  wire logic       TX_LAST,
  input  wire logic       TX_VALID,
  input  wire logic       TX_BUSY,
  output logic            TX_SOF_REQ,
  output logic            TX_READY,
  output logic            TX_ACK,
  output logic            TX_ABORT,
  output logic            BIT_TICK
);
  logic [7:0] got [0:15];
  logic [3:0] got_n;
  logic [1:0] ack_cnt;
  logic [1:0] tick;
  logic       ph;
  // ----------------------------------------
  // Frame sink, acknowledge and bit clock
  // ----------------------------------------
  initial {TX_SOF_REQ, TX_READY, TX_ACK, TX_ABORT, BIT_TICK} = 5'h0;
  always @(posedge CLK) begin
    if (RST) begin
      {TX_SOF_REQ, TX_READY, TX_ACK, TX_ABORT, BIT_TICK} <= 5'h0;
      {tick, ack_cnt, got_n, ph} <= 9'h0;
    end else begin
      tick       <= tick + 2'h1;
      BIT_TICK   <= (tick == 2'h3);
      ph         <= ~ph;
      TX_READY   <= !stall || ph;
      TX_SOF_REQ <= go;
      TX_ACK     <= (ack_cnt == 2'h1);
      TX_ABORT   <= fail && TX_BUSY && got_n == 4'h2 && !TX_ABORT;
      if (ack_cnt != 2'h0)
        ack_cnt <= ack_cnt - 2'h1;
      if (go)
        got_n <= 4'h0;
      else if (TX_VALID && TX_READY) begin
        got[got_n] <= TX_BYTE;
        got_n      <= got_n + 4'h1;
        if (TX_LAST)
          ack_cnt <= 2'h3;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/can_message_buffer_fields_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_msg_consts.vh"
module can_message_buffer_fields_tb;
  logic        CLK, RST, HWRITE, HREADYOUT, HRESP, INIT_MODE, TIME_EN, RX_DONE, go, stall;
  logic        BIT_TICK, TX_SOF_REQ, TX_ACK, TX_ABORT, TX_LAST, TX_VALID, TX_READY, TX_BUSY;
  logic        fail;
  logic [1:0]  HTRANS, TX_INDEX;
  logic [3:0]  RX_DLC;
  logic [7:0]  TX_BYTE, RX_ID_HI, RX_ID_LO;
  logic [15:0] tmr, st_exp;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [63:0] RX_DATA;
  logic [7:0]  e_hi [0:2];
  logic [7:0]  e_lo [0:2];
  logic [7:0]  e_dl [0:2];
  int          checks, miscompares, cyc, d;
  can_msg_buffers dut_u (.CLK(CLK), .RST(RST), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BIT_TICK(BIT_TICK), .INIT_MODE(INIT_MODE),
    .TIME_EN(TIME_EN), .TX_SOF_REQ(TX_SOF_REQ), .TX_ACK(TX_ACK), .TX_ABORT(TX_ABORT),
    .TX_BYTE(TX_BYTE), .TX_LAST(TX_LAST), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .TX_BUSY(TX_BUSY), .TX_INDEX(TX_INDEX), .RX_DONE(RX_DONE), .RX_ID_HI(RX_ID_HI),
    .RX_ID_LO(RX_ID_LO), .RX_DLC(RX_DLC), .RX_DATA(RX_DATA));
  can_bus_node node_u (.CLK(CLK), .RST(RST), .go(go), .stall(stall), .fail(fail),
    .TX_BYTE(TX_BYTE), .TX_LAST(TX_LAST), .TX_VALID(TX_VALID), .TX_BUSY(TX_BUSY),
    .TX_SOF_REQ(TX_SOF_REQ), .TX_READY(TX_READY), .TX_ACK(TX_ACK), .TX_ABORT(TX_ABORT),
    .BIT_TICK(BIT_TICK));
  // ----------------------------------------
  // Clock, timer reference and watchdog
  // ----------------------------------------
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    tmr <= (RST || INIT_MODE) ? 16'h0 : tmr + {15'h0, BIT_TICK};
    if ((TX_ACK || RX_DONE) && TIME_EN)
      st_exp <= tmr;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  function automatic logic [7:0] dat(input int b, input int k);
    return {b[3:0], k[3:0]} ^ 8'h5A;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] v);
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    do @(posedge CLK); while (!HREADYOUT);
    HTRANS <= 2'h0;
    HWDATA <= v;
    do @(posedge CLK); while (!HREADYOUT);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    xfer(a, 1'b0, 32'h0);
    chk(n, HRDATA, e);
  endtask
  task automatic ld(input int b, input logic [7:0] hi, lo, rk, input logic [3:0] dl);
    xfer(`A_SEL, 1'b1, 32'h1 << b);
    xfer(8'h40, 1'b1, {24'h0, hi});
    xfer(8'h44, 1'b1, {24'h0, lo});
    xfer(8'h68, 1'b1, {28'h0, dl});
    xfer(8'h6C, 1'b1, {24'h0, rk});
    for (int k = 0; k < 8; k++)
      xfer(8'h48 + 8'(4 * k), 1'b1, {24'h0, dat(b, k)});
    e_hi[b] = hi;
    e_lo[b] = lo;
    e_dl[b] = {4'h0, dl};
  endtask
  task automatic launch(input int b);
    int k;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    repeat (2) @(posedge CLK);
    chk("busy", {31'h0, TX_BUSY}, 32'h1);
    chk("index", {30'h0, TX_INDEX}, b);
    for (k = 0; k < 300 && TX_BUSY; k++)
      @(posedge CLK);
  endtask
  task automatic snd(input int b, input int n);
    launch(b);
    chk("count", node_u.got_n, n);
    chk("id upper", node_u.got[0], e_hi[b]);
    chk("id lower", node_u.got[1], e_lo[b]);
    chk("length", node_u.got[2], e_dl[b]);
    for (int k = 3; k < n; k++)
      chk("payload", node_u.got[k], dat(b, k - 3));
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fields;
    rdc(`A_STATUS, 32'h20, "status");
    rdc(`A_FLAGS, 32'h7, "flags");
    INIT_MODE <= 1'b0;
    ld(0, 8'hA5, 8'hE8, 8'h05, 4'h8);
    rdc(8'h40, 32'hA5, "id upper");
    rdc(8'h44, 32'hE8, "id lower");
    rdc(8'h68, 32'h8, "length");
    rdc(8'h6C, 32'h5, "rank");
    xfer(8'h70, 1'b1, 32'hFF);
    rdc(8'h70, 32'h0, "stamp");
    xfer(8'h3C, 1'b1, 32'hFF);
    rdc(8'h3C, 32'h0, "unmapped");
  endtask
  task automatic t_sched;
    ld(1, 8'h12, 8'h20, 8'h02, 4'h8);
    ld(2, 8'h7F, 8'hE0, 8'h02, 4'h8);
    xfer(`A_FLAGS, 1'b1, 32'h7);
    snd(1, 11);
    rdc(`A_FLAGS, 32'h2, "flags");
    snd(2, 11);
    snd(0, 11);
    rdc(`A_FLAGS, 32'h7, "flags");
  endtask
  task automatic t_length;
    stall <= 1'b0;
    for (d = 0; d < 10; d++) begin
      ld(0, 8'h55, 8'h00, 8'h01, d[3:0]);
      xfer(`A_FLAGS, 1'b1, 32'h1);
      snd(0, 3 + (d > 8 ? 8 : d));
    end
    stall <= 1'b1;
    ld(0, 8'h55, 8'h10, 8'h01, 4'h5);
    xfer(`A_FLAGS, 1'b1, 32'h1);
    snd(0, 3);
  endtask
  task automatic t_abort;
    fail <= 1'b1;
    ld(0, 8'h33, 8'h68, 8'h04, 4'h8);
    xfer(`A_FLAGS, 1'b1, 32'h1);
    launch(0);
    fail <= 1'b0;
    rdc(`A_FLAGS, 32'h6, "flags");
    rdc(8'h40, 32'h0, "blocked");
    snd(0, 11);
    rdc(8'h70, {24'h0, st_exp[15:8]}, "stamp hi");
    rdc(8'h74, {24'h0, st_exp[7:0]}, "stamp lo");
  endtask
  task automatic t_rx;
    {RX_ID_HI, RX_ID_LO, RX_DLC} <= {8'h3C, 8'h48, 4'h3};
    RX_DATA <= 64'h1122334455667788;
    RX_DONE <= 1'b1;
    @(posedge CLK);
    RX_DONE <= 1'b0;
    {RX_ID_HI, RX_ID_LO, RX_DLC, RX_DATA} <= ~{8'h3C, 8'h48, 4'h3, 64'h1122334455667788};
    @(posedge CLK);
    rdc(8'h80, 32'h3C, "rx id upper");
    rdc(8'h84, 32'h48, "rx id lower");
    rdc(8'hA8, 32'h3, "rx length");
    for (int k = 0; k < 8; k++)
      rdc(8'h88 + 8'(4 * k), k < 3 ? 8'h88 - 8'(k * 17) : 8'h0, "rx payload");
    rdc(8'hB0, {24'h0, st_exp[15:8]}, "rx stamp hi");
    rdc(8'hB4, {24'h0, st_exp[7:0]}, "rx stamp lo");
    TIME_EN <= 1'b0;
    {RX_ID_HI, RX_ID_LO, RX_DLC, RX_DATA} <= {8'h21, 8'h40, 4'h1, 64'hFFEEDDCCBBAA9900};
    RX_DONE <= 1'b1;
    @(posedge CLK);
    RX_DONE <= 1'b0;
    @(posedge CLK);
    rdc(8'h80, 32'h21, "rx id upper");
    rdc(8'h84, 32'h40, "rx id lower");
    rdc(8'hA8, 32'h1, "rx length");
    for (int k = 0; k < 3; k++)
      rdc(8'h88 + 8'(4 * k), k == 0 ? 8'h00 : 8'h88 - 8'(k * 17), "rx kept");
    rdc(8'hB4, {24'h0, st_exp[7:0]}, "rx stamp off");
  endtask
  initial begin
    {RST, INIT_MODE, TIME_EN, stall, HWRITE, RX_DONE, go, fail} <= 8'hF0;
    {HTRANS, HADDR, HWDATA} <= 66'h0;
    {RX_ID_HI, RX_ID_LO, RX_DLC, RX_DATA} <= 84'h0;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_fields();
    t_sched();
    t_length();
    t_abort();
    t_rx();
    end_of_test();
  end
endmodule
`default_nettype wire

// file: bench/can_msg_buffers_sva.sv
`timescale 1ns/1ps
`default_nettype none
module can_msg_buffers_sva (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  input wire logic       TX_SOF_REQ,
  input wire logic       TX_ACK,
  input wire logic       TX_ABORT,
  input wire logic [7:0] TX_BYTE,
  input wire logic       TX_LAST,
  input wire logic       TX_VALID,
  input wire logic       TX_READY,
  input wire logic       TX_BUSY,
  input wire logic [1:0] TX_INDEX
);
  logic       wait_r;
  logic [3:0] cnt_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // Bytes accepted in the current frame
  // ----------------------------------------
  always @(posedge CLK) begin
    if (RST || !TX_BUSY) begin
      wait_r <= 1'b0;
      cnt_r  <= 4'h0;
    end else if (TX_VALID && TX_READY) begin
      wait_r <= TX_LAST;
      cnt_r  <= cnt_r + 4'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  bus_ready_a: assert property (!$past(RST) |-> HREADYOUT && !HRESP)
    else $error("bus stalled or error response");
  busy_cause_a: assert property ($rose(TX_BUSY) |-> $past(TX_SOF_REQ))
    else $error("frame started without request");
  first_byte_a: assert property ($rose(TX_BUSY) |=> TX_VALID)
    else $error("first byte late");
  hold_byte_a: assert property (TX_VALID && !TX_READY && !TX_ABORT |=>
    TX_VALID && $stable(TX_BYTE) && $stable(TX_LAST)) else $error("byte dropped in stall");
  frame_len_a: assert property (TX_VALID && TX_READY && TX_LAST |->
    cnt_r >= 4'h2 && cnt_r <= 4'hA) else $error("frame length out of range");
  ack_idle_a: assert property (TX_ACK && wait_r |=> !TX_BUSY)
    else $error("busy after acknowledge");
  abort_idle_a: assert property (TX_ABORT && TX_BUSY |=> !TX_BUSY && !TX_VALID)
    else $error("abort not flushed");
  index_hold_a: assert property (TX_BUSY ##1 TX_BUSY |-> $stable(TX_INDEX))
    else $error("index moved in frame");
  idle_quiet_a: assert property (!TX_BUSY |-> !TX_VALID)
    else $error("byte outside frame");
endmodule
bind can_msg_buffers can_msg_buffers_sva chk_u (.CLK(CLK), .RST(RST), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .TX_SOF_REQ(TX_SOF_REQ), .TX_ACK(TX_ACK), .TX_ABORT(TX_ABORT),
  .TX_BYTE(TX_BYTE), .TX_LAST(TX_LAST), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
  .TX_BUSY(TX_BUSY), .TX_INDEX(TX_INDEX));
`default_nettype wire

// file: rtl/can_msg_buffers.v
`timescale 1ns/1ps
`default_nettype none
`include "can_msg_consts.vh"

module can_msg_buffers (
  input  wire        CLK,
  input  wire        RST,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  input  wire        BIT_TICK,
  input  wire        INIT_MODE,
  input  wire        TIME_EN,
  input  wire        TX_SOF_REQ,
  input  wire        TX_ACK,
  input  wire        TX_ABORT,
  output wire [7:0]  TX_BYTE,
  output wire        TX_LAST,
  output wire        TX_VALID,
  input  wire        TX_READY,
  output reg         TX_BUSY,
  output reg  [1:0]  TX_INDEX,
  input  wire        RX_DONE,
  input  wire [7:0]  RX_ID_HI,
  input  wire [7:0]  RX_ID_LO,
  input  wire [3:0]  RX_DLC,
  input  wire [63:0] RX_DATA
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  reg  [7:0]  id_hi_r   [0:2];
  reg  [7:0]  id_lo_r   [0:2];
  reg  [3:0]  dlc_r     [0:2];
  reg  [7:0]  rank_r    [0:2];
  reg  [15:0] stamp_r   [0:2];
  reg  [7:0]  data_r    [0:23];
  reg  [7:0]  rx_id_hi_r;
  reg  [7:0]  rx_id_lo_r;
  reg  [3:0]  rx_dlc_r;
  reg  [15:0] rx_stamp_r;
  reg  [7:0]  rx_data_r [0:7];
  reg  [2:0]  empty_r;
  reg  [2:0]  sel_r;
  reg  [15:0] timer_r;

  // ------------------------------------------------------------
  // Bus address phase capture
  // ------------------------------------------------------------
  reg         dp_wr_r;
  reg  [7:0]  dp_addr_r;
  wire        take = HSEL & HTRANS[1] & HREADY;
  wire        hs_word = (HSIZE == 3'h2);

  // Address phase captured; write data lands one cycle later
  always @(posedge CLK) begin
    if (RST) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
      HREADYOUT <= 1'b0;
      HRESP     <= 1'b0;
    end else begin
      dp_wr_r   <= take & HWRITE & hs_word;
      dp_addr_r <= HADDR[7:0];
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // Selected buffer is the lowest set select bit
  wire [1:0]  sel_idx = sel_r[0] ? 2'h0 : (sel_r[1] ? 2'h1 : 2'h2);
  wire        tx_open = |(sel_r & empty_r);
  wire [1:0]  w_win = dp_addr_r[7:6];
  wire [3:0]  w_fld = dp_addr_r[5:2];
  wire [7:0]  wd = HWDATA[7:0];
  wire        wr_tx = dp_wr_r && w_win == `WIN_TX && tx_open;
  wire [3:0]  dpw = w_fld - 4'h2;

  // ------------------------------------------------------------
  // Transmit scheduler
  // ------------------------------------------------------------
  reg  [2:0]  st_r;
  reg  [1:0]  act_r;
  reg  [3:0]  pos_r;
  reg  [1:0]  win_idx;
  reg  [7:0]  best;
  reg         found;
  integer     i;
  integer     j;
  integer     k;
  wire [2:0]  cand = ~empty_r;

  // Scan high to low so equal ranks fall to the lower index
  always @* begin
    win_idx = 2'h0;
    best    = 8'hFF;
    found   = 1'b0;
    for (i = 2; i >= 0; i = i - 1) begin
      if (cand[i] && (!found || rank_r[i] <= best)) begin
        best    = rank_r[i];
        win_idx = i[1:0];
        found   = 1'b1;
      end
    end
  end

  // Remote frames carry no payload; long codes clamp to eight
  wire [3:0]  act_dlc = dlc_r[act_r];
  wire        act_rtr = id_lo_r[act_r][`B_RTR];
  wire [3:0]  act_cnt = act_rtr ? 4'h0 :
                        (act_dlc > `MAX_BYTES ? `MAX_BYTES : act_dlc);
  wire [3:0]  last_pos = `HDR_LAST + act_cnt;
  wire [3:0]  dpos = pos_r - 4'h3;
  reg  [7:0]  tx_b;
  wire        fifo_rdy;
  wire        push = (st_r == `S_SEND) && fifo_rdy;
  wire        tx_last = (pos_r == last_pos);
  wire        abort_now = TX_ABORT && (st_r != `S_IDLE);
  wire        ack_now = TX_ACK && (st_r == `S_WAIT);

  always @* begin
    case (pos_r)
      4'h0: tx_b = id_hi_r[act_r];
      4'h1: tx_b = id_lo_r[act_r];
      4'h2: tx_b = {4'h0, act_dlc};
      default: tx_b = data_r[{act_r, dpos[2:0]}];
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      st_r     <= `S_IDLE;
      act_r    <= 2'h0;
      pos_r    <= 4'h0;
      TX_BUSY  <= 1'b0;
      TX_INDEX <= 2'h0;
    end else begin
      case (st_r)
        `S_IDLE: begin
          if (TX_SOF_REQ && found) begin
            st_r     <= `S_SEND;
            act_r    <= win_idx;
            TX_INDEX <= win_idx;
            pos_r    <= 4'h0;
            TX_BUSY  <= 1'b1;
          end
        end
        `S_SEND: begin
          if (abort_now) begin
            st_r    <= `S_IDLE;
            TX_BUSY <= 1'b0;
          end else if (push) begin
            pos_r <= pos_r + 4'h1;
            if (tx_last) begin
              st_r <= `S_WAIT;
            end
          end
        end
        `S_WAIT: begin
          if (ack_now || abort_now) begin
            st_r    <= `S_IDLE;
            TX_BUSY <= 1'b0;
          end
        end
        default: begin
          st_r    <= `S_IDLE;
          TX_BUSY <= 1'b0;
        end
      endcase
    end
  end

  // Two-entry buffer lets the link stall without losing a byte
  can_two_slot_buf u_txbuf (
    .clk       (CLK),
    .rst       (RST),
    .flush     (abort_now),
    .in_data   ({tx_last, tx_b}),
    .in_valid  (st_r == `S_SEND),
    .in_ready  (fifo_rdy),
    .out_data  ({TX_LAST, TX_BYTE}),
    .out_valid (TX_VALID),
    .out_ready (TX_READY)
  );

  // ------------------------------------------------------------
  // Flags, select, timer
  // ------------------------------------------------------------
  wire [2:0] clr_mask = (dp_wr_r && dp_addr_r == `A_FLAGS) ? HWDATA[2:0] : 3'h0;
  // Acknowledge set beats a same-cycle software clear
  wire [2:0] set_mask = ack_now ? (3'h1 << act_r) : 3'h0;
  // Select keeps only the lowest requested empty buffer
  wire [2:0] sel_req  = HWDATA[2:0] & empty_r;

  always @(posedge CLK) begin
    if (RST) begin
      empty_r <= `FLAGS_RST;
      sel_r   <= 3'h0;
      timer_r <= 16'h0000;
    end else begin
      empty_r <= (empty_r & ~clr_mask) | set_mask;
      if (dp_wr_r && dp_addr_r == `A_SEL) begin
        sel_r <= sel_req & (~sel_req + 3'h1);
      end
      if (INIT_MODE) begin
        timer_r <= 16'h0000;
      end else if (BIT_TICK) begin
        timer_r <= timer_r + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit buffer contents
  // ------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      for (j = 0; j < 3; j = j + 1) begin
        id_hi_r[j]  <= 8'h00;
        id_lo_r[j]  <= 8'h00;
        dlc_r[j]    <= 4'h0;
        rank_r[j]   <= 8'h00;
        stamp_r[j]  <= 16'h0000;
      end
      for (j = 0; j < 24; j = j + 1) begin
        data_r[j] <= 8'h00;
      end
    end else begin
      if (wr_tx) begin
        case (w_fld)
          `F_IDH:  id_hi_r[sel_idx] <= wd;
          `F_IDL:  id_lo_r[sel_idx] <= wd;
          `F_DLC:  dlc_r[sel_idx]   <= wd[3:0];
          `F_RANK: rank_r[sel_idx]  <= wd;
          `F_TSH, `F_TSL: begin
          end
          default: begin
            if (w_fld >= 4'h2 && w_fld <= 4'h9) begin
              data_r[{sel_idx, dpw[2:0]}] <= wd;
            end
          end
        endcase
      end
      if (ack_now && TIME_EN) begin
        stamp_r[act_r] <= timer_r;
      end
    end
  end

  // ------------------------------------------------------------
  // Receive buffer
  // ------------------------------------------------------------
  // Bytes past the length count keep their old contents
  wire       rx_rtr = RX_ID_LO[`B_RTR];
  wire [3:0] rx_cnt = rx_rtr ? 4'h0 :
                      (RX_DLC > `MAX_BYTES ? `MAX_BYTES : RX_DLC);

  always @(posedge CLK) begin
    if (RST) begin
      rx_id_hi_r <= 8'h00;
      rx_id_lo_r <= 8'h00;
      rx_dlc_r   <= 4'h0;
      rx_stamp_r <= 16'h0000;
      for (k = 0; k < 8; k = k + 1) begin
        rx_data_r[k] <= 8'h00;
      end
    end else if (RX_DONE) begin
      rx_id_hi_r <= RX_ID_HI;
      rx_id_lo_r <= RX_ID_LO;
      rx_dlc_r   <= RX_DLC;
      if (TIME_EN) begin
        rx_stamp_r <= timer_r;
      end
      for (k = 0; k < 8; k = k + 1) begin
        if (k < rx_cnt) begin
          rx_data_r[k] <= RX_DATA[k*8 +: 8];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Read data, registered in the address phase
  // ------------------------------------------------------------
  wire [7:0] ra = HADDR[7:0];
  wire [3:0] rf = ra[5:2];
  wire [3:0] rdi = rf - 4'h2;
  reg  [7:0] fld_tx;
  reg  [7:0] fld_rx;
  reg  [31:0] rd_nxt;

  always @* begin
    case (rf)
      `F_IDH:  fld_tx = id_hi_r[sel_idx];
      `F_IDL:  fld_tx = id_lo_r[sel_idx];
      `F_DLC:  fld_tx = {4'h0, dlc_r[sel_idx]};
      `F_RANK: fld_tx = rank_r[sel_idx];
      `F_TSH:  fld_tx = stamp_r[sel_idx][15:8];
      `F_TSL:  fld_tx = stamp_r[sel_idx][7:0];
      default: fld_tx = (rf <= 4'h9) ? data_r[{sel_idx, rdi[2:0]}] : 8'h00;
    endcase
    case (rf)
      `F_IDH:  fld_rx = rx_id_hi_r;
      `F_IDL:  fld_rx = rx_id_lo_r;
      `F_DLC:  fld_rx = {4'h0, rx_dlc_r};
      `F_TSH:  fld_rx = rx_stamp_r[15:8];
      `F_TSL:  fld_rx = rx_stamp_r[7:0];
      default: fld_rx = (rf >= 4'h2 && rf <= 4'h9) ? rx_data_r[rdi[2:0]] : 8'h00;
    endcase
    rd_nxt = 32'h00000000;
    if (ra == `A_SEL) begin
      rd_nxt = {29'h0, sel_r};
    end else if (ra == `A_FLAGS) begin
      rd_nxt = {29'h0, empty_r};
    end else if (ra == `A_STATUS) begin
      rd_nxt = {timer_r, 8'h00, st_r, TX_BUSY, 2'h0, act_r};
    end else if (ra[7:6] == `WIN_TX && tx_open) begin
      rd_nxt = {24'h0, fld_tx};
    end else if (ra[7:6] == `WIN_RX) begin
      rd_nxt = {24'h0, fld_rx};
    end
  end

  // Idle or write cycles leave the last read word standing
  always @(posedge CLK) begin
    if (RST) begin
      HRDATA <= 32'h00000000;
    end else if (take && !HWRITE) begin
      HRDATA <= rd_nxt;
    end
  end

endmodule
`default_nettype wire

// file: rtl/can_msg_consts.vh
// Summary of operation
// - Standard identifier is 11 bits; ID10 is sent first.
// - Smallest identifier value has highest bus priority.
// - ID10..3 fill upper id register; ID2..0 sit at bits 7:5 of lower.
// - Lower id bit 4 is RTR: 0 data frame, 1 remote frame.
// - Lower id bit 3 is IDE: 0 standard, 1 extended; stored or sent.
// - Eight payload bytes; only length-code bytes are sent or taken.
// - Length code in bits 3:0, plain binary, 0 to 8 data bytes.
// - Remote frame sends length code as programmed and zero data bytes.
// - Each transmit buffer holds a local rank; smaller is more urgent.
// - Before start of frame, every buffer with empty flag clear competes.
// - Smallest rank wins; ties go to the lowest buffer index.
// - With stamping on, timer is written into active buffer at acknowledge.
// - Stamp timer runs from bit clock and wraps silently.
// - Stamp timer is held at zero during initialization mode.
// - Stamp is read-only; transmit stamp read once empty and selected.
// - Software clears empty flag to send; device sets it after success.
`ifndef CAN_MSG_CONSTS_VH
`define CAN_MSG_CONSTS_VH

// ------------------------------------------------------------
// Register map (byte offsets)
// ------------------------------------------------------------
`define A_SEL      8'h00
`define A_FLAGS    8'h04
`define A_STATUS   8'h08
`define WIN_TX     2'h1
`define WIN_RX     2'h2

// ------------------------------------------------------------
// Field index inside a buffer window
// ------------------------------------------------------------
`define F_IDH      4'h0
`define F_IDL      4'h1
`define F_DLC      4'hA
`define F_RANK     4'hB
`define F_TSH      4'hC
`define F_TSL      4'hD

// ------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------
`define B_RTR      4
`define MAX_BYTES  4'h8
`define HDR_LAST   4'h2
`define FLAGS_RST  3'h7
`define BUF_W      9

// ------------------------------------------------------------
// Transmit scheduler states
// ------------------------------------------------------------
`define S_IDLE     3'h1
`define S_SEND     3'h2
`define S_WAIT     3'h4

`endif

// file: rtl/can_two_slot_buf.v
`timescale 1ns/1ps
`default_nettype none
`include "can_msg_consts.vh"

module can_two_slot_buf (
  input  wire                clk,
  input  wire                rst,
  input  wire                flush,
  input  wire [`BUF_W-1:0]   in_data,
  input  wire                in_valid,
  output reg                 in_ready,
  output reg  [`BUF_W-1:0]   out_data,
  output reg                 out_valid,
  input  wire                out_ready
);

  reg  [`BUF_W-1:0] tail_r;
  reg  [1:0]        cnt_r;
  reg  [1:0]        cnt_nxt;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  always @* begin
    cnt_nxt = cnt_r;
    if (flush) begin
      cnt_nxt = 2'h0;
    end else if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      cnt_r     <= 2'h0;
      tail_r    <= {`BUF_W{1'b0}};
      out_data  <= {`BUF_W{1'b0}};
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      in_ready  <= (cnt_nxt != 2'h2);
      out_valid <= (cnt_nxt != 2'h0);
      if (!flush) begin
        if (pop) begin
          if (cnt_r == 2'h2) begin
            out_data <= tail_r;
          end else if (push) begin
            out_data <= in_data;
          end
        end
        if (push && (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop))) begin
          out_data <= in_data;
        end else if (push) begin
          tail_r <= in_data;
        end
      end
    end
  end

endmodule
`default_nettype wire
